// file: rtl/csr_clock_reset.v
`timescale 1ns/10ps
`include "csr_regs.vh"
// What this block does
// - Eight oscillator modes from three-bit field
// - External clock mode frees second pin
// - Internal oscillator makes clock, fast or slow
// - Internal oscillator stopped while in reset
// - Firmware writes speed bit, speed applied
// - Speed bit clear slow, set fast
// - Fast to slow stalls about 100-300 us
// - Slow to fast stalls about 1.25-3.25 us
// - Clock output is internal oscillator divided by four, held low in RC clock output mode
// - Clock output held low during reset
// - Power-on and brown-out are power-up class
// - Kept registers survive non power-up resets
// - Watchdog in sleep wakes, registers unchanged
// - Status bits show last reset source
// - Reset pin filter rejects short pulses
// - Watchdog reset never drives reset pin
// - Internal power-on reset pulse on supply rise
// - Hold reset while start-up timers run
// - Pin select clear ignores reset pin
module csr_clock_reset #(
   parameter SLOW_DIV = 676,
   parameter FAST_DIV = 6,
   parameter POWER_UP_TIMER_CYC = `CSR_T_POWER_UP_TIMER_US * `CSR_CLK_MHZ,
   parameter OST_CYC = `CSR_OST_CYC,
   parameter STALL_SLOW_CYC = `CSR_T_SLOW_NS * `CSR_CLK_MHZ / 1000,
   parameter STALL_FAST_CYC = (`CSR_T_FAST_NS * `CSR_CLK_MHZ + 999) / 1000,
   parameter FILT_CYC = `CSR_FILT_CYC
)(
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst,
   // Register port
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // Reset sources
   input wire i_supply_ok,
   input wire i_brownout,
   input wire i_watchdog_timeout,
   input wire i_sleeping,
   input wire i_reset_pin_n,
   input wire i_osc_ready,
   // Second oscillator pin
   input wire i_osc2_gpio_out,
   input wire i_osc2_gpio_oe,
   output wire o_osc2_out,
   output wire o_osc2_oe,
   output wire o_osc2_is_gpio,
   // Reset pin drive, never active
   output wire o_reset_pin_out,
   output wire o_reset_pin_oe,
   // Clock and core control
   output reg o_int_osc_clk,
   output reg o_divided_clock_output,
   output wire o_core_reset,
   output wire o_cpu_stall,
   output wire o_wake,
   output wire o_init_regs
);
   localparam ST_POR = 2'h0;
   localparam ST_POWER_UP_TIMER = 2'h1;
   localparam ST_OST = 2'h2;
   localparam ST_RUN = 2'h3;
   reg [7:0] cfg_reg;
   reg [7:0] power_control_register_reg;
   reg [7:0] stat_reg;
   reg [7:0] keep_reg;
   reg [1:0] state_reg;
   reg [31:0] tmr_reg;
   reg [15:0] div_reg;
   reg [1:0] q_reg;
   reg [31:0] stall_reg;
   reg speed_reg;
   reg pwr_up_reg;
   reg [3:0] s1_reg;
   reg [3:0] s2_reg;
   reg [7:0] filt_reg;
   reg pin_rst_reg;
   reg wdt_d_reg;
   reg por_seen_reg;
   reg supply_d_reg;
   wire [2:0] fosc;
   wire int_mode;
   wire divided_clock_output_mode;
   wire xtal_mode;
   wire pin_req;
   wire wdt_rise;
   wire wdt_reset;
   wire wdt_wake;
   wire por_pulse;
   wire any_src;
   wire in_reset;
   function is_addr;
      input [7:0] a;
      input [7:0] b;
      begin
         is_addr = (a == b);
      end
   endfunction
   assign fosc = cfg_reg[`CSR_CFG_FOSC_LSB +: 3];
   assign int_mode = (fosc == `CSR_OSC_INT_IO) || (fosc == `CSR_OSC_INT_DIVIDED_CLOCK_OUTPUT);
   assign divided_clock_output_mode = (fosc == `CSR_OSC_INT_DIVIDED_CLOCK_OUTPUT) || (fosc == `CSR_OSC_RC_DIVIDED_CLOCK_OUTPUT);
   assign xtal_mode = (fosc == `CSR_OSC_LP) || (fosc == `CSR_OSC_XT) || (fosc == `CSR_OSC_HS);
   // Pin released in external clock and IO modes
   assign o_osc2_is_gpio = (fosc == `CSR_OSC_EC) || (fosc == `CSR_OSC_INT_IO)
      || (fosc == `CSR_OSC_RC_IO);
   assign o_osc2_out = o_osc2_is_gpio ? i_osc2_gpio_out : o_divided_clock_output;
   assign o_osc2_oe = o_osc2_is_gpio ? i_osc2_gpio_oe : divided_clock_output_mode;
   assign o_reset_pin_out = 1'b0;
   assign o_reset_pin_oe = 1'b0;
   // Input synchronisers
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         s1_reg <= 4'h7;
         s2_reg <= 4'h7;
      end
      else
      begin
         s1_reg <= {i_osc_ready, i_reset_pin_n, i_supply_ok, ~i_brownout};
         s2_reg <= s1_reg;
      end
   end
   // Pin request tied off when pin is an input
   assign pin_req = cfg_reg[`CSR_CFG_RESET_PIN_SELECT_BIT] & pin_rst_reg;
   assign por_pulse = s2_reg[1] & ~supply_d_reg;
   // Watchdog in sleep is a wake
   assign wdt_rise = i_watchdog_timeout & ~wdt_d_reg;
   assign wdt_wake = wdt_rise & i_sleeping;
   assign wdt_reset = wdt_rise & ~i_sleeping;
   assign o_wake = wdt_wake;
   assign any_src = por_pulse | ~s2_reg[1] | (cfg_reg[`CSR_CFG_BODEN] & ~s2_reg[0])
      | pin_req | wdt_reset;
   // Release only after sources and timers clear
   assign in_reset = any_src | (state_reg != ST_RUN);
   assign o_core_reset = in_reset;
   assign o_init_regs = in_reset;
   assign o_cpu_stall = (stall_reg != 32'h0);
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         filt_reg <= 8'h00;
         pin_rst_reg <= 1'b0;
         wdt_d_reg <= 1'b0;
         supply_d_reg <= 1'b0;
         state_reg <= ST_POR;
         tmr_reg <= 32'h0;
         pwr_up_reg <= 1'b1;
         stat_reg <= 8'h00;
         por_seen_reg <= 1'b0;
      end
      else
      begin
         wdt_d_reg <= i_watchdog_timeout;
         supply_d_reg <= s2_reg[1];
         // Pin must stay low FILT_CYC cycles
         if (s2_reg[2])
         begin
            filt_reg <= 8'h00;
            pin_rst_reg <= 1'b0;
         end
         else if (filt_reg == FILT_CYC[7:0])
            pin_rst_reg <= 1'b1;
         else
            filt_reg <= filt_reg + 8'h01;
         // Record reset cause, wake and state
         if (por_pulse)
         begin
            stat_reg[`CSR_STAT_POR] <= 1'b1;
            por_seen_reg <= 1'b1;
         end
         if (cfg_reg[`CSR_CFG_BODEN] & ~s2_reg[0])
            stat_reg[`CSR_STAT_BOR] <= 1'b1;
         if (pin_req)
            stat_reg[`CSR_STAT_EXTERNAL_RESET_PIN] <= 1'b1;
         if (wdt_reset)
            stat_reg[`CSR_STAT_WDT] <= 1'b1;
         if (wdt_wake)
            stat_reg[`CSR_STAT_WAKE] <= 1'b1;
         stat_reg[`CSR_STAT_INRST] <= in_reset;
         stat_reg[`CSR_STAT_STALL] <= o_cpu_stall;
         if (i_wr && is_addr(i_addr, `CSR_ADDR_STAT))
            stat_reg[4:0] <= stat_reg[4:0] & ~i_wdata[4:0]
               | {wdt_wake, wdt_reset, pin_req, cfg_reg[`CSR_CFG_BODEN] & ~s2_reg[0], por_pulse};
         if (any_src)
         begin
            state_reg <= ST_POR;
            tmr_reg <= 32'h0;
            pwr_up_reg <= por_pulse | ~s2_reg[1] | ~s2_reg[0] | pwr_up_reg;
         end
         else
         begin
            case (state_reg)
               ST_POR:
               begin
                  tmr_reg <= 32'h0;
                  if (pwr_up_reg && (~cfg_reg[`CSR_CFG_PWRTE] || ~s2_reg[0]))
                     state_reg <= ST_POWER_UP_TIMER;
                  else if (xtal_mode)
                     state_reg <= ST_OST;
                  else
                     state_reg <= ST_RUN;
               end
               ST_POWER_UP_TIMER:
               begin
                  if (tmr_reg >= POWER_UP_TIMER_CYC - 1)
                  begin
                     tmr_reg <= 32'h0;
                     state_reg <= xtal_mode ? ST_OST : ST_RUN;
                  end
                  else
                     tmr_reg <= tmr_reg + 32'h1;
               end
               ST_OST:
               begin
                  if (s2_reg[3] && tmr_reg >= OST_CYC - 1)
                     state_reg <= ST_RUN;
                  else
                     tmr_reg <= tmr_reg + 32'h1;
               end
               ST_RUN:
                  pwr_up_reg <= 1'b0;
               default:
                  state_reg <= ST_POR;
            endcase
         end
      end
   end
   // Registers: configuration, power control and kept byte
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         cfg_reg <= `CSR_CFG_RST;
         power_control_register_reg <= `CSR_POWER_CONTROL_REGISTER_RST;
         keep_reg <= 8'h00;
      end
      else
      begin
         if (in_reset)
            power_control_register_reg[`CSR_POWER_CONTROL_REGISTER_OSCILLATOR_SPEED_BIT] <= 1'b1;
         else if (i_wr && is_addr(i_addr, `CSR_ADDR_POWER_CONTROL_REGISTER))
            power_control_register_reg <= {4'h0, i_wdata[3], 1'b0, i_wdata[1:0]};
         // Cleared only on power-up class reset
         if (in_reset && pwr_up_reg)
            keep_reg <= 8'h00;
         else if (i_wr && is_addr(i_addr, `CSR_ADDR_KEEP))
            keep_reg <= i_wdata;
         if (i_wr && is_addr(i_addr, `CSR_ADDR_CFG))
            cfg_reg <= i_wdata;
      end
   end
   // Internal oscillator, stall and clock output
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         div_reg <= 16'h0;
         o_int_osc_clk <= 1'b0;
         q_reg <= 2'h0;
         o_divided_clock_output <= 1'b0;
         speed_reg <= 1'b1;
         stall_reg <= 32'h0;
      end
      else if (in_reset || !int_mode)
      begin
         div_reg <= 16'h0;
         o_int_osc_clk <= 1'b0;
         q_reg <= 2'h0;
         o_divided_clock_output <= 1'b0;
         speed_reg <= power_control_register_reg[`CSR_POWER_CONTROL_REGISTER_OSCILLATOR_SPEED_BIT];
         stall_reg <= 32'h0;
      end
      else
      begin
         if (speed_reg != power_control_register_reg[`CSR_POWER_CONTROL_REGISTER_OSCILLATOR_SPEED_BIT])
         begin
            speed_reg <= power_control_register_reg[`CSR_POWER_CONTROL_REGISTER_OSCILLATOR_SPEED_BIT];
            stall_reg <= speed_reg ? STALL_SLOW_CYC : STALL_FAST_CYC;
         end
         else if (stall_reg != 32'h0)
            stall_reg <= stall_reg - 32'h1;
         // Toggle at fast or slow rate
         if (div_reg >= (speed_reg ? FAST_DIV[15:0] : SLOW_DIV[15:0]) - 16'h1)
         begin
            div_reg <= 16'h0;
            o_int_osc_clk <= ~o_int_osc_clk;
            if (o_int_osc_clk)
            begin
               q_reg <= q_reg + 2'h1;
               if (q_reg[0])
                  o_divided_clock_output <= divided_clock_output_mode & ~o_divided_clock_output;
            end
         end
         else
            div_reg <= div_reg + 16'h1;
      end
   end
   // Read port
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (!i_rd)
         o_rdata <= 8'h00;
      else if (is_addr(i_addr, `CSR_ADDR_POWER_CONTROL_REGISTER))
         o_rdata <= power_control_register_reg;
      else if (is_addr(i_addr, `CSR_ADDR_CFG))
         o_rdata <= cfg_reg;
      else if (is_addr(i_addr, `CSR_ADDR_STAT))
         o_rdata <= stat_reg;
      else if (is_addr(i_addr, `CSR_ADDR_KEEP))
         o_rdata <= keep_reg;
      else
         o_rdata <= 8'h00;
   end
endmodule // csr_clock_reset

// file: rtl/csr_regs.vh
`ifndef CSR_REGS_VH
`define CSR_REGS_VH
// Register offsets (byte addresses)
`define CSR_ADDR_POWER_CONTROL_REGISTER 8'h8E
`define CSR_ADDR_CFG 8'h00
`define CSR_ADDR_STAT 8'h04
`define CSR_ADDR_KEEP 8'h08
// Power control fields
`define CSR_POWER_CONTROL_REGISTER_BOR 0
`define CSR_POWER_CONTROL_REGISTER_POR 1
`define CSR_POWER_CONTROL_REGISTER_OSCILLATOR_SPEED_BIT 3
`define CSR_POWER_CONTROL_REGISTER_RST 8'h08
// Configuration fields
`define CSR_CFG_FOSC_LSB 0
`define CSR_CFG_PWRTE 4
`define CSR_CFG_RESET_PIN_SELECT_BIT 5
`define CSR_CFG_BODEN 6
`define CSR_CFG_RST 8'h27
// Oscillator modes
`define CSR_OSC_LP 3'h0
`define CSR_OSC_XT 3'h1
`define CSR_OSC_HS 3'h2
`define CSR_OSC_EC 3'h3
`define CSR_OSC_INT_IO 3'h4
`define CSR_OSC_INT_DIVIDED_CLOCK_OUTPUT 3'h5
`define CSR_OSC_RC_IO 3'h6
`define CSR_OSC_RC_DIVIDED_CLOCK_OUTPUT 3'h7
// Status fields
`define CSR_STAT_POR 0
`define CSR_STAT_BOR 1
`define CSR_STAT_EXTERNAL_RESET_PIN 2
`define CSR_STAT_WDT 3
`define CSR_STAT_WAKE 4
`define CSR_STAT_INRST 5
`define CSR_STAT_STALL 6
// Timing
`define CSR_CLK_MHZ 50
`define CSR_T_SLOW_NS 100000
`define CSR_T_FAST_NS 1250
`define CSR_T_POWER_UP_TIMER_US 72
`define CSR_OST_CYC 1024
`define CSR_FILT_CYC 16
`endif

// file: testbench/csr_clock_reset_properties.sv
`timescale 1ns/10ps
`include "csr_regs.vh"
module csr_clock_reset_properties #(
   parameter POWER_UP_TIMER_CYC = 3600,
   parameter STALL_SLOW_CYC = 5000,
   parameter STALL_FAST_CYC = 63
)(
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst,
   // Register port
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] o_rdata,
   // Sources and pins
   input wire i_supply_ok,
   input wire i_watchdog_timeout,
   input wire i_sleeping,
   input wire i_osc2_gpio_oe,
   input wire o_osc2_oe,
   input wire o_osc2_is_gpio,
   input wire o_reset_pin_oe,
   // Clocks and core control
   input wire o_int_osc_clk,
   input wire o_divided_clock_output,
   input wire o_core_reset,
   input wire o_cpu_stall,
   input wire o_wake
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   logic [15:0] up_cnt;
   logic [15:0] st_cnt;
   logic tgt;
   // Supply age, stall length and last requested speed
   always @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
      begin
         up_cnt <= 16'h0;
         st_cnt <= 16'h0;
         tgt <= 1'b1;
      end
      else
      begin
         up_cnt <= !i_supply_ok ? 16'h0 : (&up_cnt ? up_cnt : up_cnt + 16'h1);
         st_cnt <= o_cpu_stall ? st_cnt + 16'h1 : 16'h0;
         if (i_wr && i_addr == `CSR_ADDR_POWER_CONTROL_REGISTER)
            tgt <= i_wdata[3];
      end
   AST_PIN_NEVER_DRIVEN: assert property (!o_reset_pin_oe)
      else $error("reset pin driven");
   AST_DIVIDED_CLOCK_OUTPUT_LOW: assert property (o_core_reset && $past(o_core_reset) |->
      !o_divided_clock_output) else $error("clock output high in reset");
   AST_OSC_STOPPED: assert property (o_core_reset && $past(o_core_reset) |->
      !o_int_osc_clk) else $error("oscillator runs in reset");
   AST_GPIO_PIN: assert property (o_osc2_is_gpio |-> o_osc2_oe == i_osc2_gpio_oe)
      else $error("second pin not freed");
   AST_STALL_LEN: assert property ($fell(o_cpu_stall) |-> (tgt ?
      (st_cnt >= STALL_FAST_CYC - 1 && st_cnt <= 3 * STALL_FAST_CYC) :
      (st_cnt >= STALL_SLOW_CYC - 1 && st_cnt <= 3 * STALL_SLOW_CYC)))
      else $error("stall length wrong");
   AST_RELEASE: assert property ($fell(o_core_reset) |->
      i_supply_ok && up_cnt >= POWER_UP_TIMER_CYC) else $error("early release");
   AST_WAKE: assert property ($rose(i_watchdog_timeout) && i_sleeping |->
      ##[0:4] o_wake) else $error("no wake");
   AST_WAKE_PULSE: assert property (o_wake |=> !o_wake && !o_core_reset)
      else $error("wake not a clean pulse");
   AST_WDT_RESET: assert property ($rose(i_watchdog_timeout) && !i_sleeping
      |-> ##[0:4] o_core_reset) else $error("no watchdog reset");
   AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not idle");
   cover property ($fell(o_cpu_stall));
   cover property (o_wake);
   cover property ($fell(o_core_reset));
endmodule // csr_clock_reset_properties
bind csr_clock_reset csr_clock_reset_properties #(.POWER_UP_TIMER_CYC(POWER_UP_TIMER_CYC),
   .STALL_SLOW_CYC(STALL_SLOW_CYC), .STALL_FAST_CYC(STALL_FAST_CYC)) prop_u (.*);

// file: testbench/csr_board_model.sv
`timescale 1ns/10ps
module csr_board_model (
   // Clock
   input wire i_clk_sys,
   // Board lines
   output logic o_supply_ok,
   output logic o_reset_pin_n,
   output logic o_osc_ready
);
   initial
   begin
      o_supply_ok = 1'b0;
      o_reset_pin_n = 1'b1;
      o_osc_ready = 1'b0;
   end
   task power_up;
      @(posedge i_clk_sys);
      o_supply_ok <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      o_osc_ready <= 1'b1;
   endtask
   // Pin pulled up again on release
   task pin_low(input int n);
      @(posedge i_clk_sys);
      o_reset_pin_n <= 1'b0;
      repeat (n) @(posedge i_clk_sys);
      o_reset_pin_n <= 1'b1;
   endtask
endmodule // csr_board_model

// file: testbench/csr_clock_reset_test.sv
`timescale 1ns/10ps
`include "csr_regs.vh"
module csr_clock_reset_test;
   logic i_clk_sys, i_rst, i_wr, i_rd, i_brownout, i_watchdog_timeout, i_sleeping;
   logic i_osc2_gpio_out, i_osc2_gpio_oe, i_supply_ok, i_reset_pin_n, i_osc_ready;
   logic [7:0] i_addr, i_wdata;
   wire [7:0] o_rdata;
   wire o_osc2_out, o_osc2_oe, o_osc2_is_gpio, o_reset_pin_out, o_reset_pin_oe, o_wake;
   wire o_int_osc_clk, o_divided_clock_output, o_core_reset, o_cpu_stall, o_init_regs;
   int bad_count, checked, m;
   logic w, e;
   csr_clock_reset #(.SLOW_DIV(8), .POWER_UP_TIMER_CYC(10)) dut_u (.*);
   csr_board_model board_u (.i_clk_sys(i_clk_sys), .o_supply_ok(i_supply_ok),
      .o_reset_pin_n(i_reset_pin_n), .o_osc_ready(i_osc_ready));
   task chk(input [7:0] got, input [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      if (bad_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask
   task wt(input bit s, input logic v);
      int n;
      n = 0;
      do
      begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      while ((s ? o_cpu_stall : o_core_reset) !== v && n < 6000);
      if ((s ? o_cpu_stall : o_core_reset) !== v)
      begin
         bad_count++;
         give_verdict;
      end
   endtask
   task per(input bit s, input [7:0] e);
      int n, k;
      logic p, c;
      n = 0;
      k = 0;
      p = 1'b1;
      while (k < 2 && n < 400)
      begin
         @(posedge i_clk_sys);
         #1;
         c = s ? o_divided_clock_output : o_int_osc_clk;
         n++;
         if (c && !p)
         begin
            k++;
            if (k == 1)
               n = 0;
         end
         p = c;
      end
      chk(n[7:0], e);
   endtask
   initial
   begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   initial
   begin
      {i_rst, i_wr, i_rd, i_brownout, i_watchdog_timeout, i_sleeping} = 6'h20;
      {i_osc2_gpio_out, i_osc2_gpio_oe, i_addr, i_wdata} = 18'h10000;
      bad_count = 0;
      checked = 0;
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      board_u.power_up;
      wt(0, 1'b0);
      rd(`CSR_ADDR_STAT, 8'h01);
      rd(`CSR_ADDR_POWER_CONTROL_REGISTER, `CSR_POWER_CONTROL_REGISTER_RST);
      rd(`CSR_ADDR_CFG, `CSR_CFG_RST);
      wr(`CSR_ADDR_STAT, 8'hFF);
      wr(`CSR_ADDR_KEEP, 8'hA5);
      for (m = 0; m < 8; m++)
      begin
         wr(`CSR_ADDR_CFG, 8'h20 | m[7:0]);
         i_osc2_gpio_out <= m[0];
         i_osc2_gpio_oe <= ~m[0];
         w = (m == 3) || (m == 4) || (m == 6);
         e = w ? ~m[0] : (m == 5 || m == 7);
         @(posedge i_clk_sys);
         #1;
         chk({7'h0, o_osc2_is_gpio}, {7'h0, w});
         chk({6'h0, o_osc2_oe, o_osc2_out & w}, {6'h0, e, w & m[0]});
      end
      wr(`CSR_ADDR_CFG, 8'h25);
      per(0, 8'd12);
      per(1, 8'd48);
      wr(`CSR_ADDR_POWER_CONTROL_REGISTER, 8'h00);
      @(posedge i_clk_sys);
      #1;
      chk({7'h0, o_cpu_stall}, 8'h01);
      wt(1, 1'b0);
      per(0, 8'd16);
      wr(`CSR_ADDR_POWER_CONTROL_REGISTER, 8'h08);
      @(posedge i_clk_sys);
      #1;
      chk({7'h0, o_cpu_stall}, 8'h01);
      wt(1, 1'b0);
      per(0, 8'd12);
      board_u.pin_low(10);
      repeat (30) @(posedge i_clk_sys);
      #1;
      chk({7'h0, o_core_reset}, 8'h00);
      board_u.pin_low(40);
      #1;
      chk({7'h0, o_core_reset}, 8'h01);
      wt(0, 1'b0);
      rd(`CSR_ADDR_KEEP, 8'hA5);
      rd(`CSR_ADDR_STAT, 8'h04);
      wr(`CSR_ADDR_STAT, 8'hFF);
      @(posedge i_clk_sys);
      i_watchdog_timeout <= 1'b1;
      @(posedge i_clk_sys);
      i_watchdog_timeout <= 1'b0;
      #1;
      chk({7'h0, o_core_reset}, 8'h01);
      chk({5'h0, o_reset_pin_out, o_reset_pin_oe, o_init_regs}, 8'h01);
      wt(0, 1'b0);
      rd(`CSR_ADDR_KEEP, 8'hA5);
      rd(`CSR_ADDR_STAT, 8'h08);
      wr(`CSR_ADDR_STAT, 8'hFF);
      @(posedge i_clk_sys);
      i_sleeping <= 1'b1;
      i_watchdog_timeout <= 1'b1;
      #1;
      chk({7'h0, o_wake}, 8'h01);
      @(posedge i_clk_sys);
      i_watchdog_timeout <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      #1;
      chk({7'h0, o_core_reset}, 8'h00);
      i_sleeping <= 1'b0;
      rd(`CSR_ADDR_STAT, 8'h10);
      wr(`CSR_ADDR_STAT, 8'hFF);
      wr(`CSR_ADDR_CFG, 8'h05);
      board_u.pin_low(40);
      #1;
      chk({7'h0, o_core_reset}, 8'h00);
      repeat (4) @(posedge i_clk_sys);
      wr(`CSR_ADDR_CFG, 8'h65);
      i_brownout <= 1'b1;
      wt(0, 1'b1);
      i_brownout <= 1'b0;
      wt(0, 1'b0);
      rd(`CSR_ADDR_KEEP, 8'h00);
      rd(`CSR_ADDR_STAT, 8'h02);
      give_verdict;
   end
endmodule // csr_clock_reset_test
